// file: odt_cfg.svh
// Purpose: Constants for the overrange detector and sample marker.
// Assumes: One clock, clk at 100 MHz, standing in for the sampling clock.
// Notes: Included by the package and the top module.
// Behaviour
// - Each sample gives magnitude, compared to two thresholds.
// - Offset binary folds to saturated eight-bit magnitude.
// - Flag set when magnitude reaches threshold.
// - Both channels share the same threshold pair.
// - Per channel: flag bit one high, bit zero low.
// - Single channel spreads flags; receiver ORs pairs.
// - Hold select picks eight to 1024 cycles.
// - Marked sample: upper seven bits, trigger as LSB.
// - Asynchronous trigger sampled alongside the sample.
// - Dual mode: one sample per clock per channel.
// - Single mode: two samples per clock.
// - One clock drives sampling and processing.
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH
`define ODT_SAMPLE_W 8
`define ODT_MID_CODE 8'h80
`define ODT_HOLD_BASE_LOG2 3
`define ODT_HOLD_CNT_W 11
`define ODT_FIFO_DEPTH 8
`define ODT_TRIG_SYNC_STAGES 2
`endif

// file: odt_pkg.sv
// Purpose: Shared types for the overrange detector.
// Assumes: Constants come from odt_cfg.svh.
// Notes: Channel word carries both samples of one clock.
`include "odt_cfg.svh"
package odt_pkg;
    typedef logic [`ODT_SAMPLE_W-1:0] odt_sample_t;
    typedef struct packed {
        odt_sample_t chanA;
        odt_sample_t chanB;
    } odt_pair_s;
    typedef struct packed {
        logic highFlag;
        logic lowFlag;
    } odt_flags_s;
endpackage

// file: odt_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Depth must be a power of two.
module odt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic             doWrite;
    logic             doRead;

    assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;
    assign outData  = mem[rdPtr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule

// file: odt_overrange_detect.sv
// Purpose: Overrange detection with hold pulses and sample marking.
// Assumes: Both channel samples arrive each clock as offset binary.
// Notes: In single mode sampleA and sampleB are the two edge samples.
`include "odt_cfg.svh"
module odt_overrange_detect (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              sampleValid,
    output logic                   sampleReady,
    input  wire odt_pkg::odt_pair_s sampleIn,
    input  wire logic              singleChannelMode,
    input  wire logic [7:0]        overrangeThresholdHigh,
    input  wire logic [7:0]        overrangeThresholdLow,
    input  wire logic [2:0]        overrangeHoldSelect,
    input  wire logic              sampleMarkEnable,
    input  wire logic              sampleMarkTriggerIn,
    output logic                   chanAHighFlagOut,
    output logic                   chanALowFlagOut,
    output logic                   chanBHighFlagOut,
    output logic                   chanBLowFlagOut,
    output logic                   outValid,
    input  wire logic              outReady,
    output odt_pkg::odt_pair_s     outData
);
    localparam int NCH = 2;
    localparam int FW  = $bits(odt_pkg::odt_pair_s);

    logic [`ODT_TRIG_SYNC_STAGES-1:0] trigSync;
    logic                     trigSampled;
    odt_pkg::odt_sample_t     chanSample [NCH];
    odt_pkg::odt_sample_t     chanMag    [NCH];
    odt_pkg::odt_flags_s      chanEvent  [NCH];
    odt_pkg::odt_flags_s      chanFlag   [NCH];
    logic [`ODT_HOLD_CNT_W-1:0] holdLen;
    logic                     take;
    odt_pkg::odt_pair_s       marked;
    odt_pkg::odt_pair_s       fifoOut;
    logic                     fifoValid;

    assign take = sampleValid && sampleReady;
    assign chanSample[0] = sampleIn.chanA;
    assign chanSample[1] = sampleIn.chanB;
    // Base length is widened to the counter width first so the select never wraps the amount.
    assign holdLen = `ODT_HOLD_CNT_W'(4'h1 << `ODT_HOLD_BASE_LOG2)
                     << overrangeHoldSelect;

    // Trigger pin passes two flip-flops before use.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trigSync <= '0;
        end else begin
            trigSync <= {trigSync[0], sampleMarkTriggerIn};
        end
    end
    assign trigSampled = trigSync[1];

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic [`ODT_HOLD_CNT_W-1:0] hiCnt;
            logic [`ODT_HOLD_CNT_W-1:0] loCnt;
            logic [7:0]                 centred;

            // Fold around mid code; the most negative code saturates.
            assign centred = chanSample[ch] - 8'(`ODT_MID_CODE);
            always_comb begin
                if (centred[7]) begin
                    chanMag[ch] = (centred == 8'h80) ? 8'hff :
                                  {~centred[6:0] + 7'h01, 1'b0};
                end else begin
                    chanMag[ch] = {centred[6:0], 1'b0} |
                                  {7'h00, centred[6]};
                end
            end

            // Same threshold pair on both channels.
            assign chanEvent[ch].highFlag = take &&
                (chanMag[ch] >= overrangeThresholdHigh);
            assign chanEvent[ch].lowFlag  = take &&
                (chanMag[ch] >= overrangeThresholdLow);

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    hiCnt <= '0;
                end else if (chanEvent[ch].highFlag) begin
                    hiCnt <= holdLen;
                end else if (hiCnt != '0) begin
                    hiCnt <= hiCnt - 1'b1;
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    loCnt <= '0;
                end else if (chanEvent[ch].lowFlag) begin
                    loCnt <= holdLen;
                end else if (loCnt != '0) begin
                    loCnt <= loCnt - 1'b1;
                end
            end

            assign chanFlag[ch].highFlag = hiCnt != '0;
            assign chanFlag[ch].lowFlag  = loCnt != '0;
        end
    endgenerate

    // Index zero drives the channel A pins, index one the channel B pins.
    // In single mode each channel reports its own edge sample, so the
    // receiver ORs the pair of pins.
    assign chanAHighFlagOut = chanFlag[0].highFlag;
    assign chanALowFlagOut  = chanFlag[0].lowFlag;
    assign chanBHighFlagOut = chanFlag[1].highFlag;
    assign chanBLowFlagOut  = chanFlag[1].lowFlag;

    // Timestamp replaces the LSB; the trigger lags the data by the two synchroniser flip-flops.
    always_comb begin
        marked = sampleIn;
        if (sampleMarkEnable) begin
            marked.chanA = {sampleIn.chanA[7:1], trigSampled};
            marked.chanB = {sampleIn.chanB[7:1],
                            singleChannelMode ? trigSampled : trigSampled};
        end
    end

    odt_fifo #(
        .WIDTH (FW),
        .DEPTH (`ODT_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .inData   (marked),
        .outValid (fifoValid),
        .outReady (outReady),
        .outData  (fifoOut)
    );

    assign outValid = fifoValid;
    assign outData  = fifoOut;
endmodule

// file: odt_overrange_detect_asserts.sv
// Purpose: Port checks for the overrange detector.
// Assumes: One clock domain, reset rstn.
// Notes: Counters follow the A high and B low pulses.
module odt_overrange_detect_asserts (
    input wire logic               clk, rstn, sampleValid, sampleReady,
    input wire logic               outValid, outReady,
    input wire logic               chanAHighFlagOut, chanALowFlagOut,
    input wire logic               chanBHighFlagOut, chanBLowFlagOut,
    input wire odt_pkg::odt_pair_s sampleIn, outData,
    input wire logic [7:0]         overrangeThresholdHigh,
    input wire logic [7:0]         overrangeThresholdLow,
    input wire logic [2:0]         overrangeHoldSelect
);
    function automatic logic [7:0] mag(logic [7:0] s);
        logic [7:0] n;
        n = 8'h80 - s;
        return s[7] ? {s[6:0], s[6]} : (s == 8'h00 ? 8'hff : {n[6:0], 1'b0});
    endfunction
    logic        take, evAH, evBL;
    logic [10:0] cntA, cntB, hl;
    assign take = sampleValid && sampleReady;
    assign evAH = take && mag(sampleIn.chanA) >= overrangeThresholdHigh;
    assign evBL = take && mag(sampleIn.chanB) >= overrangeThresholdLow;
    assign hl = 11'h8 << overrangeHoldSelect;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cntA <= 11'h0;
            cntB <= 11'h0;
        end else begin
            cntA <= evAH ? 11'h1 : (cntA != 0 && cntA < hl) ? cntA + 1 : 11'h0;
            cntB <= evBL ? 11'h1 : (cntB != 0 && cntB < hl) ? cntB + 1 : 11'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ahigh_exact: assert property (chanAHighFlagOut == (cntA != 0))
        else $error("A high pulse wrong");
    a_blow_exact: assert property (chanBLowFlagOut == (cntB != 0))
        else $error("B low pulse wrong");
    a_bhigh_rise: assert property (take && mag(sampleIn.chanB) >=
        overrangeThresholdHigh |=> chanBHighFlagOut) else $error("B high missed");
    a_alow_rise: assert property (take && mag(sampleIn.chanA) >=
        overrangeThresholdLow |=> chanALowFlagOut) else $error("A low missed");
    a_bhigh_quiet: assert property (!chanBHighFlagOut && !(take &&
        mag(sampleIn.chanB) >= overrangeThresholdHigh) |=> !chanBHighFlagOut)
        else $error("B high without event");
    a_hold_min: assert property ($rose(chanAHighFlagOut)
        |-> chanAHighFlagOut[*8]) else $error("pulse too short");
    a_take_out: assert property (take |=> outValid)
        else $error("taken sample not offered");
    a_out_stall: assert property (outValid && !outReady
        |=> outValid && $stable(outData)) else $error("stalled word moved");
endmodule
bind odt_overrange_detect odt_overrange_detect_asserts u_chk (.*);

// file: odt_sink.sv
// Purpose: Downstream logic taking words and watching flags.
// Assumes: Flags ordered A high, A low, B high, B low.
// Notes: stall holds ready low from the next edge.
module odt_sink (
    input wire logic               clk, stall, outValid,
    input wire odt_pkg::odt_pair_s outData,
    input wire logic [3:0]         flags,
    output logic                   outReady, highAny, lowAny
);
    odt_pkg::odt_pair_s got[$];
    initial outReady = 1'b1;
    always @(posedge clk) outReady <= !stall;
    always @(posedge clk) if (outValid && outReady) got.push_back(outData);
    assign highAny = flags[3] | flags[1];
    assign lowAny = flags[2] | flags[0];
endmodule

// file: odt_overrange_detect_test.sv
// Purpose: Self-checking bench for the overrange detector.
// Assumes: Inputs change on the falling edge.
// Notes: Rows hold sample pair, thresholds and flags.
module odt_overrange_detect_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [15:0] s, t; logic [3:0] f;} odt_row_s;
    logic clk = 0, rstn = 0, vld = 0, sm = 0, mark = 0, trig = 0, stall = 0;
    logic [15:0] smp = 0, thr = 0;
    logic [2:0] sel = 0;
    logic rdy, ov, ordy, hi, lo;
    logic [3:0] fl;
    odt_pkg::odt_pair_s od;
    int error_cnt = 0, checked = 0, n;
    odt_row_s rows[4] = '{'{16'hff80, 16'he440, 4'hc},
        '{16'h0100, 16'hfffe, 4'h7}, '{16'h80c0, 16'h0100, 4'h7},
        '{16'h3fc0, 16'h8281, 4'hd}};
    initial forever #5 clk = ~clk;
    odt_overrange_detect DUT (.clk(clk), .rstn(rstn), .sampleValid(vld),
        .sampleReady(rdy), .sampleIn(smp), .singleChannelMode(sm),
        .overrangeThresholdHigh(thr[15:8]), .overrangeThresholdLow(thr[7:0]),
        .overrangeHoldSelect(sel), .sampleMarkEnable(mark),
        .sampleMarkTriggerIn(trig), .chanAHighFlagOut(fl[3]),
        .chanALowFlagOut(fl[2]), .chanBHighFlagOut(fl[1]),
        .chanBLowFlagOut(fl[0]), .outValid(ov), .outReady(ordy), .outData(od));
    odt_sink SNK (.clk(clk), .stall(stall), .outValid(ov), .outData(od),
        .flags(fl), .outReady(ordy), .highAny(hi), .lowAny(lo));
    task cmp(string nm, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task push(logic [15:0] s);
        @(negedge clk) vld = 1;
        smp = s;
        @(negedge clk) vld = 0;
    endtask
    task hold(output int c);
        for (c = 0; fl[3] && c < 2000; c++) @(negedge clk);
    endtask
    initial begin
        #100000 error_cnt++;
        finish_test;
    end
    initial begin
        repeat (2) @(negedge clk);
        cmp("reset", 16'h1, {fl, ov, rdy});
        rstn = 1;
        foreach (rows[i]) begin
            thr = rows[i].t;
            push(rows[i].s);
            cmp("flags", rows[i].f, fl);
            repeat (10) @(negedge clk);
            cmp("data", rows[i].s, SNK.got[i]);
        end
        sm = 1;
        thr = 16'he440;
        push(16'h80ff);
        cmp("or", 16'h3, {hi, lo});
        sm = 0;
        thr = 16'hffff;
        repeat (10) @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            sel = 3'(k);
            push(16'hff00);
            hold(n);
            cmp("hold", 16'(8 << k), 16'(n));
        end
        sel = 0;
        push(16'hff00);
        repeat (4) @(negedge clk);
        push(16'hff00);
        hold(n);
        cmp("restart", 16'h8, 16'(n));
        mark = 1;
        trig = 1;
        repeat (4) @(negedge clk);
        push(16'h00fe);
        trig = 0;
        repeat (4) @(negedge clk);
        push(16'hff01);
        repeat (3) @(negedge clk);
        n = SNK.got.size();
        cmp("mark1", 16'h01ff, SNK.got[n-2]);
        cmp("mark0", 16'hfe00, SNK.got[n-1]);
        mark = 0;
        stall = 1;
        vld = 1;
        smp = 16'h1234;
        repeat (12) @(negedge clk);
        cmp("full", 16'h0, 16'(rdy));
        vld = 0;
        stall = 0;
        repeat (12) @(negedge clk);
        cmp("empty", 16'h0, 16'(ov));
        finish_test;
    end
endmodule
